// ===== design/bridge_status_pkg.sv
// constants for the primary status, revision and class code fields
// assumes a 32-bit configuration word path with four byte enables
package bridge_status_pkg;

  // byte offsets of the configuration dwords held here
  localparam logic [7:0] OFS_CMD_STATUS = 8'h04;
  localparam logic [7:0] OFS_REV_CLASS = 8'h08;

  // bit positions within the command/status dword
  localparam int BIT_CAP_LIST = 20;
  localparam int BIT_66MHZ = 21;
  localparam int BIT_FAST_B2B = 23;
  localparam int BIT_PAR_ERR = 24;
  localparam int BIT_SEL_TIM_LO = 25;
  localparam int BIT_SIG_TABORT = 27;
  localparam int BIT_RCV_TABORT = 28;
  localparam int BIT_RCV_MABORT = 29;
  localparam int BIT_SIG_SERR = 30;
  localparam int BIT_DET_PERR = 31;
  localparam int NUM_FLAGS = 6;

  // fixed read values and reset values
  localparam logic CAP_LIST_VAL = 1'b1;
  localparam logic MHZ66_VAL = 1'b0;
  localparam logic FAST_B2B_VAL = 1'b0;
  localparam logic [1:0] SEL_TIM_VAL = 2'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [7:0] PROG_IF_NORMAL = 8'h00;
  localparam logic [7:0] PROG_IF_SUBTRACT = 8'h01;
  localparam logic [7:0] SUB_CLASS_VAL = 8'h04;
  localparam logic [7:0] BASE_CLASS_VAL = 8'h06;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // byte lane that carries all six error flags
  localparam int FLAG_LANE = 3;

endpackage : bridge_status_pkg

// ===== design/w1c_flag.sv
// one sticky error flag, set by hardware, cleared by a one written by software
// assumes set and clear are single-cycle pulses on clk
`timescale 1ns/1ps
`default_nettype none
module w1c_flag
  import bridge_status_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  logic q_nxt;

  // set beats clear so an event in the clearing cycle is kept
  always_comb begin
    q_nxt = q;
    if (clr) begin
      q_nxt = 1'b0;
    end
    if (set) begin
      q_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= FLAG_RESET;
    end else if (ce) begin
      q <= q_nxt;
    end
  end

endmodule // w1c_flag
`default_nettype wire

// ===== design/bridge_primary_status_class_regs.sv
// primary status half-word, revision and class code of the bridge header
// assumes events and config strobes come from logic on clk, one cycle each
`timescale 1ns/1ps
`default_nettype none
module bridge_primary_status_class_regs
  import bridge_status_pkg::*;
#(
  parameter logic [7:0] REVISION_VAL = 8'h5A // arbitrary value
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic parity_resp_en,
  input wire logic legacy_decode,
  input wire logic rx_cpl_poisoned,
  input wire logic tx_wr_poisoned,
  input wire logic tx_cpl_abort,
  input wire logic rx_cpl_abort,
  input wire logic rx_cpl_unsupported,
  input wire logic tx_err_msg,
  input wire logic rx_tlp_poisoned,
  output logic [31:0] cfg_rdata_r,
  output logic cfg_rd_valid_r
);

  // timing at a glance, all on rising clk with ce high
  //
  // read of the status dword
  //   c0: cfg_rd high, cfg_addr at the status offset
  //   c1: cfg_rd_valid_r high, cfg_rdata_r holds the dword
  //   c2: valid drops, data stays until the next taken read
  //
  // read of the revision and class dword
  //   c0: cfg_rd high, cfg_addr at the class offset
  //   c1: revision, programming byte, sub-class and base class
  //   the programming byte is the legacy bit as seen at c0
  //
  // read of any other offset
  //   c0: cfg_rd high
  //   c1: valid high with all-zero data, never an error
  //
  // clearing a flag
  //   c0: cfg_wr high, status offset, top lane enabled, ones in flag bits
  //   c1: a read taken here already sees the flag low
  //   zeros in the write data leave their flags alone
  //   a write with the top lane off touches nothing
  //   writes to the class dword are dropped, it is read-only
  //
  // raising a flag
  //   c0: event input high
  //   c1: a read taken here already sees the flag high
  //   an event held high keeps setting the flag every cycle
  //
  // event and clear in one cycle
  //   the set wins, so an error landing during the clear is not lost
  //   software reads again after a clear to catch such a late event
  //
  // read and write in one cycle
  //   the read returns the value before the write
  //   the write takes effect at the same edge as the read capture
  //
  // clock enable low
  //   every flop holds, strobes and events are ignored
  //   a read issued then never gets a valid pulse
  //
  // reset
  //   flags, read data and valid all return to zero at once
  //   the first request may come at the first enabled edge after release
  //
  // fixed fields
  //   capability list bit reads one, the pointer lives outside this block
  //   fast back-to-back, 66 MHz and select timing read zero
  //   reserved bits of the status half read zero
  //   the command half reads zero here and is merged elsewhere
  //
  // limitations
  //   no byte-lane merge on reads, the requester masks what it needs
  //   events must come from logic on clk, none are synchronised here
  //   parity enable and legacy bit are plain levels from elsewhere

  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic [NUM_FLAGS-1:0] flag_q;
  logic [31:0] status_word;
  logic [31:0] class_word;
  logic [31:0] cfg_rdata_nxt;
  logic status_wr;
  logic wr_take;
  logic lane_flags_en;
  logic hit_status;
  logic hit_class;
  logic hit_none;
  logic rd_take;
  logic cap_list_bit;
  logic mhz66_bit;
  logic fast_b2b_bit;
  logic [1:0] select_timing_field;
  logic [3:0] rsvd_lo_field;
  logic rsvd_hi_bit;
  logic [15:0] cmd_half;
  logic [7:0] revision_byte;
  logic [7:0] prog_if_byte;
  logic [7:0] sub_class_byte;
  logic [7:0] base_class_byte;
  logic evt_par_err;
  logic evt_sig_abort;
  logic evt_rcv_abort;
  logic evt_rcv_unsup;
  logic evt_sig_err;
  logic evt_det_poison;
  logic [NUM_FLAGS-1:0] clr_bits;
  logic par_err_q;
  logic sig_abort_q;
  logic rcv_abort_q;
  logic rcv_unsup_q;
  logic sig_err_q;
  logic det_poison_q;

  // write qualifiers; ce gating also lives in each flag cell
  assign wr_take = ce && cfg_wr;
  assign lane_flags_en = cfg_be[FLAG_LANE];

  // a status write counts only when the flag byte lane is enabled
  assign status_wr = wr_take && (cfg_addr == OFS_CMD_STATUS) && lane_flags_en;

  // address decode, shared by the read mux below
  assign hit_status = (cfg_addr == OFS_CMD_STATUS);
  assign hit_class = (cfg_addr == OFS_REV_CLASS);
  assign hit_none = !(hit_status || hit_class);

  // a read is taken only on an enabled edge
  assign rd_take = ce && cfg_rd;

  // parity flag needs the response enable
  // poison in either direction counts, received completion or sent write
  assign evt_par_err = parity_resp_en && (rx_cpl_poisoned || tx_wr_poisoned);

  // completer abort returned by the bridge itself
  // one pulse per aborted request
  assign evt_sig_abort = tx_cpl_abort;

  // completer abort status in a received completion
  // raised by the completion decoder
  assign evt_rcv_abort = rx_cpl_abort;

  // unsupported-request status in a received completion
  // raised by the completion decoder
  assign evt_rcv_unsup = rx_cpl_unsupported;

  // fatal or non-fatal message sent upstream
  // correctable messages never reach this input
  assign evt_sig_err = tx_err_msg;

  // poison is flagged here whatever the parity enable says
  // so software sees poison even with parity response off
  assign evt_det_poison = rx_tlp_poisoned;

  // write-data bits that line up with the six flags
  assign clr_bits[0] = cfg_wdata[BIT_PAR_ERR];
  assign clr_bits[1] = cfg_wdata[BIT_SIG_TABORT];
  assign clr_bits[2] = cfg_wdata[BIT_RCV_TABORT];
  assign clr_bits[3] = cfg_wdata[BIT_RCV_MABORT];
  assign clr_bits[4] = cfg_wdata[BIT_SIG_SERR];
  assign clr_bits[5] = cfg_wdata[BIT_DET_PERR];

  // event sources, in flag order 24,27,28,29,30,31
  assign flag_set[0] = evt_par_err;
  assign flag_set[1] = evt_sig_abort;
  assign flag_set[2] = evt_rcv_abort;
  assign flag_set[3] = evt_rcv_unsup;
  assign flag_set[4] = evt_sig_err;
  assign flag_set[5] = evt_det_poison;

  // write-one-to-clear, zeros leave the flag alone
  assign flag_clr[0] = status_wr && clr_bits[0];
  assign flag_clr[1] = status_wr && clr_bits[1];
  assign flag_clr[2] = status_wr && clr_bits[2];
  assign flag_clr[3] = status_wr && clr_bits[3];
  assign flag_clr[4] = status_wr && clr_bits[4];
  assign flag_clr[5] = status_wr && clr_bits[5];

  // one sticky cell per error flag
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      w1c_flag u_flag (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .set(flag_set[gi]),
        .clr(flag_clr[gi]),
        .q(flag_q[gi])
      );
    end
  endgenerate

  // parity flag cell, bit 24
  assign par_err_q = flag_q[0];

  // completer abort sent, bit 27
  assign sig_abort_q = flag_q[1];

  // completer abort received, bit 28
  assign rcv_abort_q = flag_q[2];

  // unsupported request received, bit 29
  assign rcv_unsup_q = flag_q[3];

  // error message sent, bit 30
  assign sig_err_q = flag_q[4];

  // poison detected, bit 31
  assign det_poison_q = flag_q[5];

  // fixed capability bits of the status half
  assign cap_list_bit = CAP_LIST_VAL;
  assign mhz66_bit = MHZ66_VAL;
  assign fast_b2b_bit = FAST_B2B_VAL;

  // select timing is unsupported and fixed
  assign select_timing_field = SEL_TIM_VAL;

  // reserved status bits tie low and ignore writes
  assign rsvd_lo_field = 4'h0;
  assign rsvd_hi_bit = 1'b0;

  // command half is owned elsewhere; zero here keeps an OR merge safe
  assign cmd_half = 16'h0000;

  // status dword assembly, reserved nibble sits just below the capability bit
  always_comb begin
    status_word = {16'h0000, cmd_half};
    status_word[BIT_CAP_LIST-4 +: 4] = rsvd_lo_field;
    status_word[BIT_CAP_LIST] = cap_list_bit;
    status_word[BIT_66MHZ] = mhz66_bit;
    status_word[BIT_66MHZ+1] = rsvd_hi_bit;
    status_word[BIT_FAST_B2B] = fast_b2b_bit;
    status_word[BIT_PAR_ERR] = par_err_q;
    status_word[BIT_SEL_TIM_LO +: 2] = select_timing_field;
    status_word[BIT_SIG_TABORT] = sig_abort_q;
    status_word[BIT_RCV_TABORT] = rcv_abort_q;
    status_word[BIT_RCV_MABORT] = rcv_unsup_q;
    status_word[BIT_SIG_SERR] = sig_err_q;
    status_word[BIT_DET_PERR] = det_poison_q;
  end

  // revision is a fixed parameter, writes never reach it
  assign revision_byte = REVISION_VAL;

  // programming interface follows the legacy decode bit
  assign prog_if_byte = legacy_decode ? PROG_IF_SUBTRACT : PROG_IF_NORMAL;

  // bridge class, fixed
  assign sub_class_byte = SUB_CLASS_VAL;
  assign base_class_byte = BASE_CLASS_VAL;

  // class dword assembly
  assign class_word = {base_class_byte, sub_class_byte, prog_if_byte, revision_byte};

  // read mux; offsets not held here answer zero
  // the hits are exclusive, so the order of the ifs does not matter
  always_comb begin
    cfg_rdata_nxt = RDATA_RESET;
    if (hit_status) begin
      cfg_rdata_nxt = status_word;
    end
    if (hit_class) begin
      cfg_rdata_nxt = class_word;
    end
    if (hit_none) begin
      cfg_rdata_nxt = 32'h0000_0000;
    end
  end

  // valid pulse marks the cycle after each taken read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rd_valid_r <= 1'b0;
    end else if (ce) begin
      cfg_rd_valid_r <= rd_take;
    end
  end

  // read data registered so the answer comes one cycle after the strobe
  // and holds until the next taken read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata_r <= RDATA_RESET;
    end else if (rd_take) begin
      cfg_rdata_r <= cfg_rdata_nxt;
    end
  end

endmodule // bridge_primary_status_class_regs
`default_nettype wire

// ===== dv/status_props.sv
// checker for the status and class code read values
// bound to the register block, watches its ports only
`timescale 1ns/1ps
`default_nettype none
module status_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic legacy_decode,
  input wire logic tx_cpl_abort,
  input wire logic rx_cpl_abort,
  input wire logic rx_tlp_poisoned,
  input wire logic [31:0] cfg_rdata_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // taken reads of the two dwords
  wire logic rd4 = ce && cfg_rd && cfg_addr == 8'h04;
  wire logic rd8 = ce && cfg_rd && cfg_addr == 8'h08;
  property p_cap; rd4 |=> cfg_rdata_r[20]; endproperty
  a_cap: assert property (p_cap) else $error("cap bit low");
  property p_fbb; rd4 |=> !cfg_rdata_r[23]; endproperty
  a_fbb: assert property (p_fbb) else $error("b2b bit high");
  property p_sel; rd4 |=> cfg_rdata_r[26:25] == 2'h0; endproperty
  a_sel: assert property (p_sel) else $error("timing field");
  property p_cls; rd8 |=> cfg_rdata_r[31:16] == 16'h0604; endproperty
  a_cls: assert property (p_cls) else $error("class code");
  property p_pif; rd8 |=> cfg_rdata_r[15:8] == {7'h00, $past(legacy_decode)}; endproperty
  a_pif: assert property (p_pif) else $error("prog byte");
  // event, one quiet cycle, then a status read
  property p_sta; ce && tx_cpl_abort ##2 rd4 |=> cfg_rdata_r[27]; endproperty
  a_sta: assert property (p_sta) else $error("abort sent");
  property p_rta; ce && rx_cpl_abort ##2 rd4 |=> cfg_rdata_r[28]; endproperty
  a_rta: assert property (p_rta) else $error("abort seen");
  property p_dpe; ce && rx_tlp_poisoned ##2 rd4 |=> cfg_rdata_r[31]; endproperty
  a_dpe: assert property (p_dpe) else $error("poison seen");
endmodule // status_props
bind bridge_primary_status_class_regs status_props i_props (.clk, .arst_n, .ce, .cfg_rd, .cfg_addr,
  .legacy_decode, .tx_cpl_abort, .rx_cpl_abort, .rx_tlp_poisoned, .cfg_rdata_r);
`default_nettype wire

// ===== dv/cfg_requester.sv
// upstream requester model issuing single dword config accesses
// drives at the falling edge so each request spans one rising edge
`timescale 1ns/1ps
`default_nettype none
module cfg_requester (
  input wire logic clk,
  output logic cfg_rd,
  output logic cfg_wr,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata_r,
  input wire logic cfg_rd_valid_r
);
  initial {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = '0;
  // released fields flip so stale values never match by luck
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk) {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge clk) {cfg_rd, cfg_addr} = {1'b0, ~a};
    d = cfg_rd_valid_r ? cfg_rdata_r : 'x;
  endtask
  // ones clear flags, zeros leave them
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] w);
    @(negedge clk) {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, b, w};
    @(negedge clk) {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b0, ~a, ~b, ~w};
  endtask
endmodule // cfg_requester
`default_nettype wire

// ===== dv/tb_top.sv
// bench for primary status, revision and class code
// drives inputs at the falling edge of a 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bridge_status_pkg::*;
  logic clk = 0, arst_n = 0, ce = 1, par_en = 1, legacy = 0, cfg_rd, cfg_wr, cfg_rd_valid_r;
  logic [6:0] ev = '0;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata_r, d, m;
  int n_mismatch = 0, total_checks = 0;
  int bp[7] = '{24, 24, 27, 28, 29, 30, 31};
  localparam logic [31:0] IDLE = 32'h0010_0000;
  always #25 clk = ~clk;
  bridge_primary_status_class_regs i_dut (.clk, .arst_n, .ce, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be,
    .cfg_wdata, .parity_resp_en(par_en), .legacy_decode(legacy), .rx_cpl_poisoned(ev[0]),
    .tx_wr_poisoned(ev[1]), .tx_cpl_abort(ev[2]), .rx_cpl_abort(ev[3]), .rx_cpl_unsupported(ev[4]),
    .tx_err_msg(ev[5]), .rx_tlp_poisoned(ev[6]), .cfg_rdata_r, .cfg_rd_valid_r);
  cfg_requester i_rc (.clk, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata_r, .cfg_rd_valid_r);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one pulse on an event input
  task automatic pulse(input logic [6:0] v);
    @(negedge clk) ev = v;
    @(negedge clk) ev = '0;
  endtask
  // hang guard, far beyond the roughly 150 cycles used
  initial begin
    #100000;
    n_mismatch++;
    stop_test;
  end
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1;
    i_rc.rd(8'h04, d);
    chk(d, IDLE);
    i_rc.wr(8'h08, 4'hF, '1);
    i_rc.rd(8'h08, d);
    chk(d, {BASE_CLASS_VAL, SUB_CLASS_VAL, PROG_IF_NORMAL, 8'h5A});
    legacy = 1;
    i_rc.rd(8'h08, d);
    chk(d, 32'h0604_015A);
    i_rc.rd(8'h40, d);
    chk(d, '0);
    // every event source, then lane-off and zero writes, then a real clear
    for (int i = 0; i < 7; i++) begin
      m = 32'h0000_0001 << bp[i];
      pulse(7'h01 << i);
      i_rc.rd(8'h04, d);
      chk(d, IDLE | m);
      i_rc.wr(8'h04, 4'h7, '1);
      i_rc.wr(8'h04, 4'hF, ~m);
      i_rc.rd(8'h04, d);
      chk(d, IDLE | m);
      i_rc.wr(8'h04, 4'hF, m);
      i_rc.rd(8'h04, d);
      chk(d, IDLE);
    end
    // an event in the clearing cycle survives the clear
    fork
      pulse(7'h40);
      i_rc.wr(8'h04, 4'hF, 32'h8000_0000);
    join
    i_rc.rd(8'h04, d);
    chk(d, IDLE | 32'h8000_0000);
    // mid-run reset drops the bit 31 flag left set by the test above
    @(negedge clk) arst_n = 0;
    repeat (2) @(negedge clk);
    arst_n = 1;
    i_rc.rd(8'h04, d);
    chk(d, IDLE);
    // clock enable low: event ignored, read gets no valid pulse
    @(negedge clk) ce = 0;
    pulse(7'h40);
    i_rc.rd(8'h04, d);
    chk({31'h0, cfg_rd_valid_r}, 32'h0);
    ce = 1;
    i_rc.rd(8'h04, d);
    chk(d, IDLE);
    par_en = 0;
    pulse(7'h03);
    i_rc.rd(8'h04, d);
    chk(d, IDLE);
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
